// *** src/aarc_ctrl.sv ***
// Purpose: acknowledgment start timing and automatic retransmit transaction sequencing
// Assumes: radio datapath reports frame end, CCA result, ACK receipt by pulses
// Notes: backoff itself lives outside; one CSMA attempt is a request/response pair

// Notes on behaviour
// - ack delay select clear: start ack twelve symbols after frame end
// - ack delay select set: start ack two symbols (32 us) after frame end
// - slotted mode waits for pin rising edge, result shows waiting for trigger
// - slotted ack frame is ready three symbols after the last symbol
// - transmission starts 16 us after the host trigger edge
// - enter receiving state on start delimiter, frame done marks completion
// - default timing sends the ack alone after twelve-symbol turnaround
// - transaction starts by pin rising edge or transmit-go command
// - run channel access, transmit buffered frame when channel idle
// - busy channel retried to limit, then abort with access failed code 3
// - ack request taken from bit 5 of first PSDU octet
// - no ack requested: frame done after transmit, result success 0
// - await matching valid ack, result 0 or 1 from pending bit
// - no ack within 54 symbols retries; past limit result 5
// - current frame and channel access retry counts are exposed
// - frame buffer untouched; frames other than expected ack dropped
// - tx timestamp only with pin route and timestamp enables both set
// - result reads 7 while a transaction is unfinished
// - channel access limit 7: transmit at once, single attempt
module aarc_ctrl #(
    parameter int SYMBOL_CYCLES = aarc_pkg::SYMBOL_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic auto_ack_receive_mode_in,
    input wire logic auto_retry_transmit_state_in,
    input wire logic ack_delay_select_in,
    input wire logic slotted_enable_in,
    input wire logic sleep_transmit_pin_in,
    input wire logic tx_go_cmd_in,
    input wire logic [2:0] channel_access_retry_limit_in,
    input wire logic [3:0] frame_retry_limit_in,
    input wire logic start_irq_pin_route_enable_in,
    input wire logic tx_timestamp_enable_in,
    input wire logic sfd_detect_in,
    input wire logic rx_frame_end_in,
    input wire logic rx_ack_request_in,
    input wire logic rx_ack_frame_in,
    input wire logic rx_seq_match_in,
    input wire logic rx_fcs_ok_in,
    input wire logic rx_frame_pending_in,
    input wire logic [7:0] tx_octet_in,
    input wire logic tx_octet_valid_in,
    input wire logic [7:0] tx_octet_index_in,
    input wire logic tx_done_in,
    input wire logic cca_done_in,
    input wire logic cca_idle_in,
    output logic csma_start_out,
    output logic tx_start_out,
    output logic tx_timestamp_out,
    output logic rx_enable_out,
    output logic rx_discard_out,
    output logic receiving_auto_ack_state_out,
    output logic frame_done_irq_out,
    output logic [2:0] transaction_result_out,
    output logic [3:0] frame_retry_count_out,
    output logic [2:0] channel_access_retry_count_out,
    output logic buffer_write_protect_out
);
    typedef enum logic [3:0] {
        AARC_IDLE = 4'h0,
        AARC_RX = 4'h1,
        AARC_ACK_DELAY = 4'h3,
        AARC_ACK_TRIG = 4'h2,
        AARC_ACK_START = 4'h6,
        AARC_ACK_TX = 4'h7,
        AARC_CSMA = 4'h5,
        AARC_TX = 4'h4,
        AARC_ACK_WAIT = 4'hC,
        AARC_FINISH = 4'hD
    } aarc_state_e;

    aarc_state_e state_reg, state_next;
    logic pin_d_reg;
    logic ack_req_reg;
    logic ready_reg;
    logic [2:0] result_reg;
    logic [3:0] fr_cnt_reg;
    logic [2:0] ca_cnt_reg;
    logic timer_done;
    logic timer_start;
    logic timer_raw;
    logic [15:0] timer_count;

    function automatic logic [15:0] sym16(input int n);
        sym16 = n[15:0];
    endfunction

    wire pin_rise = sleep_transmit_pin_in && !pin_d_reg;
    wire no_csma = (channel_access_retry_limit_in == aarc_pkg::CSMA_OFF_LIMIT);
    wire tx_trigger = pin_rise || tx_go_cmd_in;
    wire valid_ack = rx_ack_frame_in && rx_seq_match_in && rx_fcs_ok_in;
    wire ca_exhausted = (ca_cnt_reg >= channel_access_retry_limit_in);
    wire fr_exhausted = no_csma || (fr_cnt_reg >= frame_retry_limit_in);
    wire first_octet = tx_octet_valid_in && (tx_octet_index_in == 8'h01);
    wire stamp_ok = start_irq_pin_route_enable_in && tx_timestamp_enable_in;
    wire ack_timeout = (state_reg == AARC_ACK_WAIT) && timer_done;
    wire rx_ack_end = (state_reg == AARC_RX) && rx_frame_end_in && rx_ack_request_in;
    wire trig_ok = (state_reg == AARC_ACK_TRIG) && pin_rise && ready_reg;
    wire cca_busy = (state_reg == AARC_CSMA) && cca_done_in && !cca_idle_in;
    wire fail_access = cca_busy && ca_exhausted;
    wire retry_csma = cca_busy && !ca_exhausted;
    wire tx_end = (state_reg == AARC_TX) && tx_done_in;
    wire retry_frame = ack_timeout && !fr_exhausted;
    wire ok_ack = (state_reg == AARC_ACK_WAIT) && valid_ack;
    // every way a transaction ends raises frame done once
    wire done_event = fail_access || (tx_end && !ack_req_reg) || ok_ack ||
        (ack_timeout && fr_exhausted);
    wire begin_tx = (state_reg == AARC_IDLE) && auto_retry_transmit_state_in && tx_trigger;
    wire launch_csma = begin_tx || retry_csma || retry_frame;

    // timer loads: symbol counts for delays, raw cycles only for the 16 us trigger gap
    assign timer_start = rx_ack_end || trig_ok || (tx_end && ack_req_reg);
    assign timer_raw = trig_ok;
    assign timer_count = trig_ok ? sym16(aarc_pkg::TRIG_START_CYCLES) :
        tx_end ? sym16(aarc_pkg::ACK_TIMEOUT_SYMBOLS) :
        slotted_enable_in ? sym16(aarc_pkg::ACK_READY_SYMBOLS) :
        ack_delay_select_in ? sym16(aarc_pkg::ACK_SHORT_SYMBOLS) :
        sym16(aarc_pkg::ACK_STD_SYMBOLS);

    // one shared timer; a good ack stops it so no stale expiry lingers
    aarc_symbol_timer #(
        .SYMBOL_CYCLES(SYMBOL_CYCLES)
    ) u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .start_in(timer_start),
        .stop_in(ok_ack),
        .raw_in(timer_raw),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    // triggers outside idle are simply not decoded
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            AARC_IDLE: begin
                if (begin_tx) begin
                    state_next = no_csma ? AARC_TX : AARC_CSMA;
                end else if (auto_ack_receive_mode_in && sfd_detect_in) begin
                    state_next = AARC_RX;
                end
            end
            AARC_RX: begin
                if (rx_ack_end) begin
                    state_next = slotted_enable_in ? AARC_ACK_TRIG : AARC_ACK_DELAY;
                end else if (rx_frame_end_in) begin
                    state_next = AARC_IDLE;
                end
            end
            AARC_ACK_DELAY: begin
                if (timer_done) begin
                    state_next = AARC_ACK_TX;
                end
            end
            AARC_ACK_TRIG: begin
                if (trig_ok) begin
                    state_next = AARC_ACK_START;
                end
            end
            AARC_ACK_START: begin
                if (timer_done) begin
                    state_next = AARC_ACK_TX;
                end
            end
            AARC_ACK_TX: begin
                if (tx_done_in) begin
                    state_next = AARC_IDLE;
                end
            end
            AARC_CSMA: begin
                if (cca_done_in && cca_idle_in) begin
                    state_next = AARC_TX;
                end else if (fail_access) begin
                    state_next = AARC_FINISH;
                end
            end
            AARC_TX: begin
                if (tx_end) begin
                    state_next = ack_req_reg ? AARC_ACK_WAIT : AARC_FINISH;
                end
            end
            AARC_ACK_WAIT: begin
                if (ok_ack || (ack_timeout && fr_exhausted)) begin
                    state_next = AARC_FINISH;
                end else if (retry_frame) begin
                    state_next = AARC_CSMA;
                end
            end
            AARC_FINISH: begin
                state_next = AARC_IDLE;
            end
            default: begin
                state_next = AARC_IDLE;
            end
        endcase
    end

    // code picked from whichever end event fires
    wire [2:0] result_next = fail_access ? aarc_pkg::RES_ACCESS_FAIL :
        ok_ack ? (rx_frame_pending_in ? aarc_pkg::RES_PENDING : aarc_pkg::RES_SUCCESS) :
        ack_timeout ? aarc_pkg::RES_NO_ACK : aarc_pkg::RES_SUCCESS;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_reg <= AARC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // delay stage idles low like the pin, so no false edge follows reset
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= sleep_transmit_pin_in;
        end
    end

    // ready flag: trigger edge before the ack is prepared is ignored
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || rx_ack_end) begin
            ready_reg <= 1'b0;
        end else if (state_reg == AARC_ACK_TRIG && timer_done) begin
            ready_reg <= 1'b1;
        end
    end

    // only octet one carries the request flag; the rest is payload
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || begin_tx) begin
            ack_req_reg <= 1'b0;
        end else if (state_reg == AARC_TX && first_octet) begin
            ack_req_reg <= tx_octet_in[aarc_pkg::ACK_REQ_BIT];
        end
    end

    // final code and start marker never meet in one cycle
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            result_reg <= aarc_pkg::RES_RESET;
        end else if (done_event && state_reg != AARC_FINISH) begin
            result_reg <= result_next;
        end else if (begin_tx) begin
            result_reg <= aarc_pkg::RES_INVALID;
        end else if (rx_ack_end && slotted_enable_in) begin
            result_reg <= aarc_pkg::RES_WAIT_TRIG;
        end else if (trig_ok) begin
            result_reg <= aarc_pkg::RES_SUCCESS;
        end
    end

    // counts clear at start, and the access count also on each frame retry, so the host reads the current tries
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || begin_tx) begin
            fr_cnt_reg <= 4'h0;
        end else if (retry_frame) begin
            fr_cnt_reg <= fr_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in || begin_tx || retry_frame) begin
            ca_cnt_reg <= 3'h0;
        end else if (retry_csma) begin
            ca_cnt_reg <= ca_cnt_reg + 3'h1;
        end
    end

    // strobes fire on the cycle a sending state is entered
    wire enter_tx = (state_reg != AARC_TX) && (state_next == AARC_TX);
    wire enter_ack_tx = (state_reg != AARC_ACK_TX) && (state_next == AARC_ACK_TX);
    wire in_txn = (state_reg == AARC_CSMA) || (state_reg == AARC_TX) ||
        (state_reg == AARC_ACK_WAIT) || (state_reg == AARC_FINISH);
    wire rx_listen = (state_next == AARC_ACK_WAIT) || (state_next == AARC_RX);
    wire drop_frame = (state_reg == AARC_ACK_WAIT) && rx_frame_end_in && !valid_ack;
    wire rx_done = (state_reg == AARC_RX) && rx_frame_end_in;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            csma_start_out <= 1'b0;
            tx_start_out <= 1'b0;
            tx_timestamp_out <= 1'b0;
        end else begin
            csma_start_out <= launch_csma && !no_csma;
            tx_start_out <= enter_tx || enter_ack_tx;
            tx_timestamp_out <= enter_tx && stamp_ok;
        end
    end

    // enable follows the next state so the radio listens on entry
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_enable_out <= 1'b0;
            rx_discard_out <= 1'b0;
            receiving_auto_ack_state_out <= 1'b0;
        end else begin
            rx_enable_out <= rx_listen;
            rx_discard_out <= drop_frame;
            receiving_auto_ack_state_out <= (state_next == AARC_RX);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            frame_done_irq_out <= 1'b0;
            transaction_result_out <= aarc_pkg::RES_RESET;
        end else begin
            frame_done_irq_out <= done_event || rx_done;
            transaction_result_out <= result_reg;
        end
    end

    // copied every cycle so the host sees them mid-transaction
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            frame_retry_count_out <= 4'h0;
            channel_access_retry_count_out <= 3'h0;
        end else begin
            frame_retry_count_out <= fr_cnt_reg;
            channel_access_retry_count_out <= ca_cnt_reg;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            buffer_write_protect_out <= 1'b0;
        end else begin
            buffer_write_protect_out <= in_txn || (state_next == AARC_CSMA);
        end
    end
endmodule

// *** src/aarc_pkg.sv ***
// Purpose: shared constants for the auto-ack and auto-retry controller
// Assumes: 125 MHz system clock, 16 us symbol period
// Notes: result codes follow the transaction result field encoding
package aarc_pkg;
    localparam int CLK_MHZ = 125;
    localparam int SYMBOL_US = 16;
    localparam int SYMBOL_CYCLES = SYMBOL_US * CLK_MHZ;
    localparam int ACK_STD_SYMBOLS = 12;
    localparam int ACK_SHORT_US = 32;
    localparam int ACK_SHORT_SYMBOLS = ACK_SHORT_US / SYMBOL_US;
    localparam int ACK_READY_SYMBOLS = 3;
    localparam int TRIG_START_US = 16;
    localparam int TRIG_START_CYCLES = TRIG_START_US * CLK_MHZ;
    localparam int ACK_TIMEOUT_US = 864;
    localparam int ACK_TIMEOUT_SYMBOLS = ACK_TIMEOUT_US / SYMBOL_US;
    localparam int ACK_REQ_BIT = 5;
    localparam logic [2:0] CSMA_OFF_LIMIT = 3'h7;
    localparam logic [2:0] RES_SUCCESS = 3'h0;
    localparam logic [2:0] RES_PENDING = 3'h1;
    localparam logic [2:0] RES_WAIT_TRIG = 3'h2;
    localparam logic [2:0] RES_ACCESS_FAIL = 3'h3;
    localparam logic [2:0] RES_NO_ACK = 3'h5;
    localparam logic [2:0] RES_INVALID = 3'h7;
    localparam logic [2:0] RES_RESET = 3'h0;
endpackage

// *** src/aarc_symbol_timer.sv ***
// Purpose: counts a number of symbol periods, or raw cycles, after a start pulse
// Assumes: start_in is a one-cycle pulse; restarting reloads the count
// Notes: done_out pulses once when the count expires
module aarc_symbol_timer #(
    parameter int SYMBOL_CYCLES = 2000
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic raw_in,
    input wire logic [15:0] count_in,
    output logic done_out
);
    logic [15:0] sym_reg;
    logic [15:0] cyc_reg;
    logic run_reg;
    logic raw_reg;
    wire tick = (cyc_reg == 16'h0001);
    wire last = tick && (raw_reg || sym_reg == 16'h0001);

    always_ff @(posedge sys_clk_in) begin
        if (reset_in || stop_in) begin
            run_reg <= 1'b0;
            sym_reg <= 16'h0000;
            cyc_reg <= 16'h0000;
            raw_reg <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            run_reg <= 1'b1;
            raw_reg <= raw_in;
            sym_reg <= count_in;
            cyc_reg <= raw_in ? count_in : SYMBOL_CYCLES[15:0];
            done_out <= 1'b0;
        end else if (run_reg) begin
            done_out <= last;
            run_reg <= !last;
            if (tick) begin
                sym_reg <= sym_reg - 16'h0001;
                cyc_reg <= SYMBOL_CYCLES[15:0];
            end else begin
                cyc_reg <= cyc_reg - 16'h0001;
            end
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule

// *** verif/aarc_ctrl_sva.sv ***
// Purpose: port assertions for the auto-ack and auto-retry controller
// Assumes: limits and enables held steady during a transaction
// Notes: bound to aarc_ctrl at the foot of this file
module aarc_ctrl_sva (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic auto_retry_transmit_state_in,
    input wire logic [2:0] channel_access_retry_limit_in,
    input wire logic start_irq_pin_route_enable_in,
    input wire logic tx_timestamp_enable_in,
    input wire logic rx_ack_frame_in,
    input wire logic rx_seq_match_in,
    input wire logic rx_fcs_ok_in,
    input wire logic rx_frame_pending_in,
    input wire logic cca_done_in,
    input wire logic cca_idle_in,
    input wire logic csma_start_out,
    input wire logic tx_start_out,
    input wire logic tx_timestamp_out,
    input wire logic rx_enable_out,
    input wire logic frame_done_irq_out,
    input wire logic [2:0] transaction_result_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    wire ack_ok = auto_retry_transmit_state_in && rx_enable_out && rx_ack_frame_in
        && rx_seq_match_in && rx_fcs_ok_in;
    a_done_one_cycle: assert property (frame_done_irq_out |=> !frame_done_irq_out)
        else $error("frame done longer than one cycle");
    a_result_final: assert property ((frame_done_irq_out && auto_retry_transmit_state_in) |=>
        transaction_result_out inside {3'h0, 3'h1, 3'h3, 3'h5})
        else $error("result not final after frame done");
    a_no_csma_seven: assert property (csma_start_out |-> channel_access_retry_limit_in != 3'h7)
        else $error("channel access run with limit seven");
    a_stamp_enables: assert property (tx_timestamp_out |->
        (start_irq_pin_route_enable_in && tx_timestamp_enable_in))
        else $error("timestamp without both enables");
    a_stamp_at_start: assert property (tx_timestamp_out |-> tx_start_out)
        else $error("timestamp apart from transmit start");
    a_ack_result: assert property (ack_ok |=> frame_done_irq_out ##1
        transaction_result_out == {2'h0, $past(rx_frame_pending_in, 2)})
        else $error("valid ack result wrong");
    a_csma_invalid: assert property (csma_start_out |=> transaction_result_out == 3'h7)
        else $error("result not invalid during channel access");
    a_idle_sends: assert property ((auto_retry_transmit_state_in && cca_done_in && cca_idle_in)
        |=> tx_start_out)
        else $error("idle channel did not start transmit");
    c_ack: cover property (ack_ok);
    c_stamp: cover property (tx_timestamp_out);
    c_csma_tx: cover property (csma_start_out ##[1:20] tx_start_out);
endmodule

bind aarc_ctrl aarc_ctrl_sva i_sva (.sys_clk_in, .reset_in, .auto_retry_transmit_state_in,
    .channel_access_retry_limit_in, .start_irq_pin_route_enable_in, .tx_timestamp_enable_in,
    .rx_ack_frame_in, .rx_seq_match_in, .rx_fcs_ok_in, .rx_frame_pending_in, .cca_done_in,
    .cca_idle_in, .csma_start_out, .tx_start_out, .tx_timestamp_out, .rx_enable_out,
    .frame_done_irq_out, .transaction_result_out);

// *** verif/aarc_radio_model.sv ***
// Purpose: radio datapath model answering channel access and transmit requests
// Assumes: requests are one-cycle pulses, one at a time
// Notes: cca_idle_out and octet_out left idle show inverted last value, octet_index_out moves to 02, so stale data is never trusted
module aarc_radio_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic csma_start_in,
    input wire logic tx_start_in,
    input wire logic [3:0] busy_n_in,
    input wire logic ack_req_in,
    output logic cca_done_out = 1'h0,
    output logic cca_idle_out = 1'h0,
    output logic [7:0] octet_out = 8'h00,
    output logic octet_valid_out = 1'h0,
    output logic [7:0] octet_index_out = 8'h00,
    output logic tx_done_out = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_cca = 0;
    always @(posedge clk_in) begin
        if (go_in) n_cca = 0;
        if (csma_start_in) begin
            repeat (3) @(posedge clk_in);
            #1 cca_idle_out = (n_cca >= busy_n_in);
            cca_done_out = 1'h1;
            n_cca++;
            @(posedge clk_in);
            #1 cca_done_out = 1'h0;
            cca_idle_out = ~cca_idle_out;
        end
    end
    always @(posedge clk_in) begin
        if (tx_start_in) begin
            #1 octet_index_out = 8'h01;
            octet_out = {2'h0, ack_req_in, 5'h03};
            octet_valid_out = 1'h1;
            @(posedge clk_in);
            #1 octet_valid_out = 1'h0;
            octet_out = ~octet_out;
            octet_index_out = 8'h02;
            repeat (3) @(posedge clk_in);
            #1 tx_done_out = 1'h1;
            @(posedge clk_in);
            #1 tx_done_out = 1'h0;
        end
    end
endmodule

// *** verif/tb.sv ***
// Purpose: self-checking bench for the auto-ack and auto-retry controller
// Assumes: four clocks per symbol in simulation
// Notes: timing expectations derive from SC, except the trigger gap, taken from TRIG_START_CYCLES
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 4;
    logic sys_clk_in = 1'h0, reset_in = 1'h1, auto_ack_receive_mode_in = 1'h0;
    logic auto_retry_transmit_state_in = 1'h0, ack_delay_select_in = 1'h0;
    logic slotted_enable_in = 1'h0, sleep_transmit_pin_in = 1'h0, tx_go_cmd_in = 1'h0;
    logic [2:0] channel_access_retry_limit_in = 3'h3;
    logic [3:0] frame_retry_limit_in = 4'h3, busy_n = 4'h0;
    logic start_irq_pin_route_enable_in = 1'h1, tx_timestamp_enable_in = 1'h1;
    logic sfd_detect_in = 1'h0, rx_frame_end_in = 1'h0, rx_ack_request_in = 1'h1;
    logic rx_ack_frame_in = 1'h0, rx_seq_match_in = 1'h1, rx_fcs_ok_in = 1'h1;
    logic rx_frame_pending_in = 1'h0, ack_req = 1'h0;
    logic [7:0] tx_octet_in, tx_octet_index_in;
    logic tx_octet_valid_in, tx_done_in, cca_done_in, cca_idle_in;
    logic csma_start_out, tx_start_out, tx_timestamp_out, rx_enable_out, rx_discard_out;
    logic receiving_auto_ack_state_out, frame_done_irq_out, buffer_write_protect_out;
    logic [2:0] transaction_result_out, channel_access_retry_count_out;
    logic [3:0] frame_retry_count_out;
    int n_mismatch = 0, total_checks = 0, n_txs = 0, n_ts = 0, n_fd = 0, s0, s1;

    aarc_ctrl #(.SYMBOL_CYCLES(SC)) i_dut (.*);
    aarc_radio_model i_radio (.clk_in(sys_clk_in), .go_in(tx_go_cmd_in | sleep_transmit_pin_in),
        .csma_start_in(csma_start_out), .tx_start_in(tx_start_out), .busy_n_in(busy_n),
        .ack_req_in(ack_req), .cca_done_out(cca_done_in), .cca_idle_out(cca_idle_in),
        .octet_out(tx_octet_in), .octet_valid_out(tx_octet_valid_in),
        .octet_index_out(tx_octet_index_in), .tx_done_out(tx_done_in));

    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        n_txs += tx_start_out;
        n_ts += tx_timestamp_out;
        n_fd += frame_done_irq_out;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // registered pins plus edge detect allow a few cycles of slack
    function automatic logic near(input int c, input int e);
        return c >= e && c <= e + 3;
    endfunction
    task automatic wait_tx(output int cyc);
        cyc = 0;
        do begin
            tick(1);
            cyc++;
        end while (tx_start_out !== 1'h1 && cyc < 3000);
    endtask
    task automatic rx_ack(input logic sel, input logic slot);
        int cyc;
        int fd;
        ack_delay_select_in = sel;
        slotted_enable_in = slot;
        auto_ack_receive_mode_in = 1'h1;
        sfd_detect_in = 1'h1;
        tick(1);
        sfd_detect_in = 1'h0;
        tick(1);
        chk("rx_state", 1, receiving_auto_ack_state_out);
        fd = n_fd;
        rx_frame_end_in = 1'h1;
        tick(1);
        rx_frame_end_in = 1'h0;
        if (slot) begin
            tick(2);
            chk("wait_trig", aarc_pkg::RES_WAIT_TRIG, transaction_result_out);
            // early edge before the ack is ready must be ignored
            sleep_transmit_pin_in = 1'h1;
            tick(1);
            sleep_transmit_pin_in = 1'h0;
            tick(3 * SC);
            sleep_transmit_pin_in = 1'h1;
            wait_tx(cyc);
            sleep_transmit_pin_in = 1'h0;
            chk("trig_gap", 1, near(cyc, aarc_pkg::TRIG_START_CYCLES));
        end else begin
            wait_tx(cyc);
            chk("ack_gap", 1, near(cyc, (sel ? 2 : 12) * SC));
        end
        chk("rx_done", 16'(fd + 1), 16'(n_fd));
        tick(10);
        auto_ack_receive_mode_in = 1'h0;
    endtask
    task automatic tx(input logic [2:0] cl, input logic [3:0] fl, input logic [3:0] busy,
            input logic ar, input int ack, input logic pin);
        int cyc;
        logic sent;
        tick(2);
        channel_access_retry_limit_in = cl;
        frame_retry_limit_in = fl;
        busy_n = busy;
        ack_req = ar;
        s0 = n_txs;
        s1 = n_ts;
        sent = 1'h0;
        tx_go_cmd_in = !pin;
        sleep_transmit_pin_in = pin;
        tick(1);
        tx_go_cmd_in = 1'h0;
        sleep_transmit_pin_in = 1'h0;
        tick(2);
        chk("res_busy", aarc_pkg::RES_INVALID, transaction_result_out);
        chk("frame_retries", 0, frame_retry_count_out);
        chk("protect", 1, buffer_write_protect_out);
        cyc = 0;
        while (frame_done_irq_out !== 1'h1 && cyc < 3000) begin
            if (rx_enable_out === 1'h1 && ack >= 0 && !sent) begin
                rx_ack_frame_in = 1'h1;
                rx_frame_end_in = 1'h1;
                rx_seq_match_in = 1'h0;
                rx_frame_pending_in = ack[0];
                tick(1);
                rx_frame_end_in = 1'h0;
                rx_seq_match_in = 1'h1;
                chk("discard", 1, rx_discard_out);
                tick(1);
                chk("keep", 0, rx_discard_out);
                rx_ack_frame_in = 1'h0;
                sent = 1'h1;
            end else begin
                tick(1);
            end
            cyc++;
        end
        chk("done_seen", 1, cyc < 3000);
        tick(1);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(8 * 30000);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        tick(4);
        reset_in = 1'h0;
        rx_ack(1'h0, 1'h0);
        rx_ack(1'h1, 1'h0);
        rx_ack(1'h0, 1'h1);
        auto_retry_transmit_state_in = 1'h1;
        tx(3'h3, 4'h3, 4'h0, 1'h0, -1, 1'h0);
        chk("res_plain", aarc_pkg::RES_SUCCESS, transaction_result_out);
        chk("stamps", 1, 16'(n_ts - s1));
        tx_timestamp_enable_in = 1'h0;
        tx(3'h3, 4'h3, 4'h1, 1'h1, 1, 1'h1);
        chk("res_pend", aarc_pkg::RES_PENDING, transaction_result_out);
        chk("no_stamp", 0, 16'(n_ts - s1));
        tx(3'h3, 4'h3, 4'h0, 1'h1, 0, 1'h0);
        chk("res_ack", aarc_pkg::RES_SUCCESS, transaction_result_out);
        tx(3'h3, 4'h1, 4'h0, 1'h1, -1, 1'h0);
        chk("res_noack", aarc_pkg::RES_NO_ACK, transaction_result_out);
        chk("attempts", 2, 16'(n_txs - s0));
        chk("fr_retries", 1, frame_retry_count_out);
        tx(3'h2, 4'h3, 4'h7, 1'h0, -1, 1'h0);
        chk("res_busy_ch", aarc_pkg::RES_ACCESS_FAIL, transaction_result_out);
        chk("no_send", 0, 16'(n_txs - s0));
        chk("ca_retries", 2, channel_access_retry_count_out);
        tx(3'h7, 4'h3, 4'h7, 1'h1, -1, 1'h0);
        chk("res_once", aarc_pkg::RES_NO_ACK, transaction_result_out);
        chk("single", 1, 16'(n_txs - s0));
        print_verdict();
    end
endmodule
